// ### bench/reclock_da_status_mode_control_bench.sv
// Self-checking bench for the reclocking DA status and mode control
`timescale 1ns/1ps
module reclock_da_status_mode_control_bench
    import rda_pkg::*;
;
    logic        ref_clk, srst, regWrStrobe, regRdStrobe;
    logic [7:0]  regAddr;
    logic [31:0] regWrData, regRdData, rdv;
    logic        controlModeJumper, retimeBypassJumper, carrierDetect;
    logic [2:0]  detectedRate, retimeRate;
    logic [9:0]  cableLength;
    logic        internalFault, converterOk, initDone, fwUpdating;
    logic        busActivity, faultIndicator, busActivityIndicator;
    logic        configuringIndicator, powerIndicator, outputMute;
    logic        remoteOverrideIndicator, carrierDetectIndicator;
    logic        reclockIndicator, retimeEnable;
    logic [4:0]  rateIndicator;
    int          badCount = 0;
    int          nCompared = 0;
    int          ones;
    // Mute table: expected mute, rate, cable length at each boundary
    localparam logic [13:0] MUTE_TAB [6] = '{
        {1'b1, RATE_270, SD_MUTE_M + 10'h001}, {1'b0, RATE_270, SD_MUTE_M},
        {1'b1, RATE_1G5, HD_MUTE_LO_M},
        {1'b0, RATE_1G5, HD_MUTE_LO_M - 10'h001},
        {1'b1, RATE_1G5, HD_MUTE_HI_M},
        {1'b0, RATE_1G5, HD_MUTE_HI_M + 10'h001}};

    // Short counts keep flash and hold periods visible in a short run
    reclock_da_status_mode_control #(.LONG_HALF(8), .SHORT_HALF(2),
        .ACT_HOLD(20), .LOCATE_LEN(40), .CHANGE_LEN(10)) i_dut (.*);
    remote_ctl_model i_remote (.ref_clk(ref_clk), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe),
        .regRdStrobe(regRdStrobe), .regRdData(regRdData));

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp)
        begin
            badCount++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic results();
        $display("Compared %0d mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : settle

    // Pins pass a filter and may start a mode change, so allow 30 cycles
    task automatic setPins(input logic c, input logic [2:0] r,
                           input logic [9:0] len);
        @(posedge ref_clk);
        carrierDetect <= c;
        detectedRate <= r;
        cableLength <= len;
        settle(30);
    endtask : setPins

    // Count cycles with the chosen indicator lit
    task automatic count(input int n, input logic bus, output int k);
        k = 0;
        repeat (n)
        begin
            @(posedge ref_clk);
            k += bus ? busActivityIndicator : faultIndicator;
        end
    endtask : count

    task automatic tInit();
        settle(10);
        check(32'(configuringIndicator), 32'h1);
        initDone <= 1'b1;
        settle(30);
        check(32'(configuringIndicator), 32'h0);
        check(32'(powerIndicator), 32'h1);
        converterOk <= 1'b0;
        settle(10);
        check(32'(powerIndicator), 32'h0);
        converterOk <= 1'b1;
        settle(10);
    endtask : tInit

    task automatic tRates();
        for (logic [2:0] r = RATE_143; r <= RATE_1G5; r++)
        begin
            setPins(1'b1, r, 10'h000);
            check(32'(rateIndicator), 32'h1 << (r - 3'h1));
            check(32'(retimeRate), 32'(r));
            check(32'(carrierDetectIndicator), 32'h1);
            check({retimeEnable, reclockIndicator, outputMute}, 3'h4);
        end
        setPins(1'b1, RATE_NONE, 10'h000);
        i_remote.rd(STAT_OFS, rdv);
        check(32'(rdv[2:0]), 32'(RATE_NONE));
        // Codes above the supported set must also read as bypass
        setPins(1'b1, 3'h7, 10'h000);
        check(32'(retimeRate), 32'(RATE_NONE));
        setPins(1'b0, RATE_270, 10'h000);
        check(32'(carrierDetectIndicator), 32'h0);
        check(32'(outputMute), 32'h1);
    endtask : tRates

    task automatic tMute();
        foreach (MUTE_TAB[i])
        begin
            setPins(1'b1, MUTE_TAB[i][12:10], MUTE_TAB[i][9:0]);
            check(32'(outputMute), 32'(MUTE_TAB[i][13]));
        end
    endtask : tMute

    task automatic tBypass();
        retimeBypassJumper <= 1'b1;
        setPins(1'b1, RATE_270, 10'h0fa);
        check({retimeEnable, reclockIndicator}, 2'h1);
        check(32'(outputMute), 32'h1);
        i_remote.rd(STAT_OFS, rdv);
        check(32'(rdv[2:0]), 32'(RATE_NONE));
        setPins(1'b1, RATE_270, 10'h000);
        check(32'(outputMute), 32'h0);
        retimeBypassJumper <= 1'b0;
        settle(30);
        check(32'(reclockIndicator), 32'h0);
    endtask : tBypass

    task automatic tRemote();
        controlModeJumper <= 1'b0;
        i_remote.stage(RATE_177);
        settle(30);
        check(32'(retimeRate), 32'(RATE_270));
        i_remote.rd(CTRL_OFS, rdv);
        check(rdv, {26'h0, RATE_177, 3'h4});
        i_remote.apply();
        settle(30);
        check(32'(retimeRate), 32'(RATE_177));
        check(32'(remoteOverrideIndicator), 32'h1);
        count(32, 1'b0, ones);
        check(32'(ones), 32'd16);
        controlModeJumper <= 1'b1;
        settle(30);
        check(32'(retimeRate), 32'(RATE_270));
        check(32'(remoteOverrideIndicator), 32'h0);
        controlModeJumper <= 1'b0;
        i_remote.wr(CMD_OFS, 32'h1 << CMD_RECALL);
        settle(30);
        i_remote.rd(STAT_OFS, rdv);
        check(32'(rdv[6]), 32'h0);
        check(32'(remoteOverrideIndicator), 32'h0);
        // Remote bypass override, then recall back to the jumper
        i_remote.wr(CTRL_OFS, (32'h1 << CTRL_BYP_OVR)
                              | (32'h1 << CTRL_BYP_VAL));
        i_remote.apply();
        settle(30);
        check(32'(reclockIndicator), 32'h1);
        check(32'(remoteOverrideIndicator), 32'h1);
        i_remote.wr(CMD_OFS, 32'h1 << CMD_RECALL);
        settle(30);
        check(32'(reclockIndicator), 32'h0);
        i_remote.rd(CMD_OFS, rdv);
        check(rdv, 32'h0);
        i_remote.rd(8'h10, rdv);
        check(rdv, 32'h0);
    endtask : tRemote

    task automatic tFault();
        internalFault <= 1'b1;
        settle(10);
        count(16, 1'b0, ones);
        check(32'(ones), 32'd16);
        internalFault <= 1'b0;
        settle(10);
        count(16, 1'b0, ones);
        check(32'(ones), 32'd0);
        fwUpdating <= 1'b1;
        settle(10);
        check(32'(configuringIndicator), 32'h1);
        fwUpdating <= 1'b0;
        settle(10);
        check(32'(configuringIndicator), 32'h0);
    endtask : tFault

    // Locate must outrank the activity stretch its own write starts
    task automatic tBus();
        settle(40);
        count(16, 1'b1, ones);
        check(32'(ones), 32'd0);
        busActivity <= 1'b1;
        settle(6);
        count(16, 1'b1, ones);
        check(32'(ones), 32'd8);
        busActivity <= 1'b0;
        settle(40);
        i_remote.wr(CMD_OFS, 32'h1 << CMD_LOCATE);
        // The locate timer loads on the strobe edge; skip its first cycle
        settle(1);
        count(32, 1'b1, ones);
        check(32'(ones), 32'd16);
    endtask : tBus

    // Inputs at time zero, reset held two cycles
    initial
    begin
        srst = 1'b1;
        {controlModeJumper, retimeBypassJumper, carrierDetect} = 3'h0;
        {internalFault, initDone, fwUpdating, busActivity} = 4'h0;
        converterOk = 1'b1;
        detectedRate = RATE_NONE;
        cableLength = 10'h000;
        settle(2);
        srst <= 1'b0;
        check({configuringIndicator, outputMute, powerIndicator},
              3'h6);
        tInit();
        tRates();
        tMute();
        tBypass();
        tRemote();
        tFault();
        tBus();
        results();
    end

    // Watchdog against a hang
    initial
    begin
        settle(20000);
        badCount++;
        results();
    end
endmodule : reclock_da_status_mode_control_bench

// ### bench/remote_ctl_model.sv
// Remote network controller model driving the register port
`timescale 1ns/1ps
module remote_ctl_model
    import rda_pkg::*;
(
    // Clock
    input  wire logic        ref_clk,
    // Register port
    output logic      [7:0]  regAddr,
    output logic      [31:0] regWrData,
    output logic             regWrStrobe,
    output logic             regRdStrobe,
    input  wire logic [31:0] regRdData
);
    // Idle bus, no strobes before reset ends
    initial
    begin
        regAddr = 8'hff;
        regWrData = 32'h0;
        regWrStrobe = 1'b0;
        regRdStrobe = 1'b0;
    end

    // Released lines show inverted values so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge ref_clk);
        regWrStrobe <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask : wr

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge ref_clk);
        regRdStrobe <= 1'b0;
        regAddr <= ~a;
        @(posedge ref_clk);
        d = regRdData;
    endtask : rd

    task automatic stage(input logic [2:0] rate);
        wr(CTRL_OFS, {26'h0, rate, 3'h4});
    endtask : stage

    task automatic apply();
        wr(CMD_OFS, 32'h1 << CMD_APPLY);
    endtask : apply
endmodule : remote_ctl_model

// ### core/flash_divider.sv
// Free-running divider making long and short flash patterns
`timescale 1ns/1ps
module flash_divider
#(
    parameter int unsigned LONG_HALF  = 4,
    parameter int unsigned SHORT_HALF = 2
)
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic srst,
    // Flash patterns
    flash_if.src      fl
);

    logic [31:0] longCnt_r;
    logic [31:0] shortCnt_r;
    logic        long_r;
    logic        short_r;

    // Long pattern; runs regardless of what is shown on the LEDs
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            longCnt_r <= 32'h0;
            long_r    <= 1'b0;
        end
        else if (longCnt_r >= LONG_HALF - 1)
        begin
            longCnt_r <= 32'h0;
            long_r    <= ~long_r;
        end
        else
        begin
            longCnt_r <= longCnt_r + 32'h1;
        end
    end

    // Short pattern
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            shortCnt_r <= 32'h0;
            short_r    <= 1'b0;
        end
        else if (shortCnt_r >= SHORT_HALF - 1)
        begin
            shortCnt_r <= 32'h0;
            short_r    <= ~short_r;
        end
        else
        begin
            shortCnt_r <= shortCnt_r + 32'h1;
        end
    end

    assign fl.longFlash  = long_r;
    assign fl.shortFlash = short_r;

endmodule : flash_divider

// ### core/flash_if.sv
// Flash pattern carrier between divider and indicator logic
`timescale 1ns/1ps
interface flash_if;
    logic longFlash;
    logic shortFlash;

    modport src (output longFlash, output shortFlash);
    modport snk (input longFlash, input shortFlash);
endinterface : flash_if

// ### core/rda_pkg.sv
// Constants shared by the reclocking DA status and mode-control logic
package rda_pkg;

    // Clock rate in kHz and indicator timing in milliseconds
    localparam int unsigned CLK_KHZ        = 200000;
    localparam int unsigned LONG_HALF_MS   = 500;
    localparam int unsigned SHORT_HALF_MS  = 100;
    localparam int unsigned ACT_HOLD_MS    = 200;
    localparam int unsigned LOCATE_MS      = 5000;
    localparam int unsigned CHANGE_MS      = 20;

    // Derived cycle counts, all above 4096 so the bench overrides them
    localparam int unsigned LONG_HALF_CYC  = LONG_HALF_MS * CLK_KHZ;
    localparam int unsigned SHORT_HALF_CYC = SHORT_HALF_MS * CLK_KHZ;
    localparam int unsigned ACT_HOLD_CYC   = ACT_HOLD_MS * CLK_KHZ;
    localparam int unsigned LOCATE_CYC     = LOCATE_MS * CLK_KHZ;
    localparam int unsigned CHANGE_CYC     = CHANGE_MS * CLK_KHZ;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CMD_OFS  = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;

    // Control register field positions
    localparam int CTRL_BYP_OVR = 0;
    localparam int CTRL_BYP_VAL = 1;
    localparam int CTRL_MANUAL  = 2;
    localparam int CTRL_RATE_LO = 3;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // Command register bit positions (write-one pulses)
    localparam int CMD_APPLY  = 0;
    localparam int CMD_RECALL = 1;
    localparam int CMD_LOCATE = 2;

    // Data-rate codes; zero means bypass or no valid rate
    localparam logic [2:0] RATE_NONE = 3'h0;
    localparam logic [2:0] RATE_143  = 3'h1;
    localparam logic [2:0] RATE_177  = 3'h2;
    localparam logic [2:0] RATE_270  = 3'h3;
    localparam logic [2:0] RATE_360  = 3'h4;
    localparam logic [2:0] RATE_1G5  = 3'h5;

    // Cable-length mute limits in meters
    localparam logic [9:0] SD_MUTE_M   = 10'h15e;  // 350
    localparam logic [9:0] HD_MUTE_LO_M = 10'h0c8; // 200
    localparam logic [9:0] HD_MUTE_HI_M = 10'h12c; // 300

    // Pin synchroniser width
    localparam int PIN_W = 21;

    // Configuration state
    typedef enum logic [2:0] {
        ST_INIT   = 3'b001,
        ST_RUN    = 3'b010,
        ST_CHANGE = 3'b100
    } cfgState_t;

endpackage : rda_pkg

// ### core/reclock_da_status_mode_control.sv
// Indicator, mute and reclock-mode control for the reclocking DA
`timescale 1ns/1ps
// Behaviour
// - Configuring lit during init, power lit
// - Fault: off, steady internal, long-flash config
// - Bus LED: off, short-flash activity, long-flash locate
// - Configuring on during init, change, update
// - Power on unless converter failed
// - Override LED when remote overrides jumpers
// - Carrier LED follows carrier detect
// - Reclock LED off auto, on bypass
// - Light retimeRate LED with carrier; none in bypass
// - Mute outputs: no input or over-range
// - Pass input in its received format
// - Control jumper: local only or both
// - Retime jumper: reclock or bypass all
// - Lockout jumper only; manual standard remote only
// - Auto without valid rate reports bypass
// - Recall default returns to auto
// - Rates 143, 177, 270, 360M, 1.5G
// - Mute SD over 350m, HD/bypass 200-300m
module reclock_da_status_mode_control
    import rda_pkg::*;
#(
    parameter int unsigned LONG_HALF  = LONG_HALF_CYC,
    parameter int unsigned SHORT_HALF = SHORT_HALF_CYC,
    parameter int unsigned ACT_HOLD   = ACT_HOLD_CYC,
    parameter int unsigned LOCATE_LEN = LOCATE_CYC,
    parameter int unsigned CHANGE_LEN = CHANGE_CYC
)
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrStrobe,
    input  wire logic        regRdStrobe,
    output logic      [31:0] regRdData,
    // Jumpers and board status pins
    input  wire logic        controlModeJumper,
    input  wire logic        retimeBypassJumper,
    input  wire logic        carrierDetect,
    input  wire logic [2:0]  detectedRate,
    input  wire logic [9:0]  cableLength,
    input  wire logic        internalFault,
    input  wire logic        converterOk,
    input  wire logic        initDone,
    input  wire logic        fwUpdating,
    input  wire logic        busActivity,
    // Indicators
    output logic             faultIndicator,
    output logic             busActivityIndicator,
    output logic             configuringIndicator,
    output logic             powerIndicator,
    output logic             remoteOverrideIndicator,
    output logic             carrierDetectIndicator,
    output logic             reclockIndicator,
    output logic      [4:0]  rateIndicator,
    // Datapath control
    output logic             outputMute,
    output logic             retimeEnable,
    output logic      [2:0]  retimeRate
);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // Pin synchronisers: three stages, accept when stages two and three agree
    logic [PIN_W-1:0] pinRaw;
    logic [PIN_W-1:0] syncA_r;
    logic [PIN_W-1:0] syncB_r;
    logic [PIN_W-1:0] syncC_r;
    logic [PIN_W-1:0] pinF_r;

    assign pinRaw = {cableLength, detectedRate, busActivity, fwUpdating,
                     initDone, converterOk, internalFault, carrierDetect,
                     retimeBypassJumper, controlModeJumper};

    // Whole vectors in one process, so every bit has a single driver
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            syncA_r <= {PIN_W{1'b0}};
            syncB_r <= {PIN_W{1'b0}};
            syncC_r <= {PIN_W{1'b0}};
            pinF_r  <= {PIN_W{1'b0}};
        end
        else
        begin
            syncA_r <= pinRaw;
            syncB_r <= syncA_r;
            syncC_r <= syncB_r;
            pinF_r  <= (pinF_r & (syncB_r ^ syncC_r))
                       | (syncC_r & ~(syncB_r ^ syncC_r));
        end
    end

    logic       localOnlyF;
    logic       jmpBypassF;
    logic       carrierF;
    logic       faultF;
    logic       convOkF;
    logic       initDoneF;
    logic       fwUpdF;
    logic       activityF;
    logic [2:0] rateF;
    logic [9:0] cableF;

    assign localOnlyF = pinF_r[0];
    assign jmpBypassF = pinF_r[1];
    assign carrierF   = pinF_r[2];
    assign faultF     = pinF_r[3];
    assign convOkF    = pinF_r[4];
    assign initDoneF  = pinF_r[5];
    assign fwUpdF     = pinF_r[6];
    assign activityF  = pinF_r[7];
    assign rateF      = pinF_r[10:8];
    assign cableF     = pinF_r[20:11];

    // Register decode
    logic ctrlWr;
    logic applyCmd;
    logic recallCmd;
    logic locateCmd;

    assign ctrlWr    = regWrStrobe && (regAddr == CTRL_OFS);
    assign applyCmd  = regWrStrobe && (regAddr == CMD_OFS)
                       && regWrData[CMD_APPLY];
    assign recallCmd = regWrStrobe && (regAddr == CMD_OFS)
                       && regWrData[CMD_RECALL];
    assign locateCmd = regWrStrobe && (regAddr == CMD_OFS)
                       && regWrData[CMD_LOCATE];

    // Staged remote selection; only a write stores it, and only apply acts on it
    logic [5:0] ctrlStage_r;
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            ctrlStage_r <= CTRL_RESET;
        else if (ctrlWr)
            ctrlStage_r <= regWrData[5:0];
    end

    // Active remote selection
    logic [5:0] ctrlAct_r;
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            ctrlAct_r <= CTRL_RESET;
        else if (recallCmd)
            ctrlAct_r <= CTRL_RESET;
        else if (applyCmd)
            ctrlAct_r <= ctrlStage_r;
    end

    // Effective mode; the lockout comes only from the jumper
    logic       remoteOn;
    logic       bypassEff;
    logic       manualEff;
    logic [2:0] manualRate;
    logic       rateValid;
    logic       manualValid;
    logic [2:0] curRate;

    assign remoteOn   = !localOnlyF;
    assign bypassEff  = (remoteOn && ctrlAct_r[CTRL_BYP_OVR])
                        ? ctrlAct_r[CTRL_BYP_VAL] : jmpBypassF;
    assign manualEff  = remoteOn && ctrlAct_r[CTRL_MANUAL];
    assign manualRate = ctrlAct_r[CTRL_RATE_LO +: 3];
    assign rateValid   = (rateF >= RATE_143) && (rateF <= RATE_1G5);
    assign manualValid = (manualRate >= RATE_143)
                         && (manualRate <= RATE_1G5);

    always_comb
    begin
        if (bypassEff)
            curRate = RATE_NONE;
        else if (manualEff)
            curRate = manualValid ? manualRate : RATE_NONE;
        else
            curRate = rateValid ? rateF : RATE_NONE;
    end

    // Configuration problem: manual rate disagrees with a valid input
    logic cfgProblem;
    assign cfgProblem = manualEff && !bypassEff && carrierF && rateValid
                        && (rateF != manualRate);

    // Over-range mute
    logic sdReclock;
    logic overRange;
    assign sdReclock = !bypassEff && (curRate >= RATE_143)
                       && (curRate <= RATE_360);
    assign overRange = sdReclock ? (cableF > SD_MUTE_M)
                       : ((cableF >= HD_MUTE_LO_M)
                          && (cableF <= HD_MUTE_HI_M));

    // Datapath control registers
    // mute on loss or range
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            outputMute   <= 1'b1;
            retimeEnable <= 1'b0;
            retimeRate   <= RATE_NONE;
        end
        else
        begin
            outputMute   <= !carrierF || overRange;
            retimeEnable <= (curRate != RATE_NONE);
            retimeRate   <= curRate;
        end
    end

    // Configuration state; a mode change holds the configuring LED
    cfgState_t   state_r;
    logic [10:0] modeWord;
    logic [10:0] modeWord_r;
    logic [31:0] chgCnt_r;
    assign modeWord = {localOnlyF, bypassEff, manualEff, curRate,
                       ctrlAct_r[4:0]};

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            state_r    <= ST_INIT;
            chgCnt_r   <= 32'h0;
            modeWord_r <= 11'h000;
        end
        else
        begin
            modeWord_r <= modeWord;
            case (state_r)
                ST_INIT:
                    if (initDoneF)
                        state_r <= ST_RUN;
                ST_RUN:
                    if (modeWord != modeWord_r)
                    begin
                        state_r  <= ST_CHANGE;
                        chgCnt_r <= 32'h0;
                    end
                ST_CHANGE:
                    if (modeWord != modeWord_r)
                        chgCnt_r <= 32'h0;
                    else if (chgCnt_r >= CHANGE_LEN - 1)
                        state_r <= ST_RUN;
                    else
                        chgCnt_r <= chgCnt_r + 32'h1;
                default:
                    state_r <= ST_INIT;
            endcase
        end
    end

    // Flash patterns
    flash_if flashBus ();
    flash_divider #(
        .LONG_HALF  (LONG_HALF),
        .SHORT_HALF (SHORT_HALF)
    ) uFlash (
        .ref_clk (ref_clk),
        .srst    (srst),
        .fl      (flashBus.src)
    );

    // Activity stretch and locate timer; locate outranks activity
    logic [31:0] actCnt_r;
    logic [31:0] locCnt_r;
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            actCnt_r <= 32'h0;
        else if (activityF || regWrStrobe || regRdStrobe)
            actCnt_r <= ACT_HOLD;
        else if (actCnt_r != 32'h0)
            actCnt_r <= actCnt_r - 32'h1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            locCnt_r <= 32'h0;
        else if (locateCmd)
            locCnt_r <= LOCATE_LEN;
        else if (locCnt_r != 32'h0)
            locCnt_r <= locCnt_r - 32'h1;
    end

    // Indicator registers
    logic [4:0] rateOneHot;
    always_comb
    begin
        rateOneHot = 5'h00;
        if (carrierF && (curRate != RATE_NONE))
            rateOneHot[curRate - 3'h1] = 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            faultIndicator          <= 1'b0;
            busActivityIndicator    <= 1'b0;
            configuringIndicator    <= 1'b1;
            powerIndicator          <= 1'b0;
            remoteOverrideIndicator <= 1'b0;
            carrierDetectIndicator  <= 1'b0;
            reclockIndicator        <= 1'b0;
            rateIndicator           <= 5'h00;
        end
        else
        begin
            faultIndicator <= faultF
                              || (cfgProblem && flashBus.longFlash);
            busActivityIndicator <= (locCnt_r != 32'h0)
                                    ? flashBus.longFlash
                                    : ((actCnt_r != 32'h0)
                                       && flashBus.shortFlash);
            configuringIndicator <= (state_r != ST_RUN) || fwUpdF;
            powerIndicator <= convOkF;
            remoteOverrideIndicator <= remoteOn
                                       && (manualEff
                                           || (bypassEff != jmpBypassF));
            carrierDetectIndicator <= carrierF;
            reclockIndicator <= bypassEff;
            rateIndicator <= rateOneHot;
        end
    end

    // Read data, one cycle after the read strobe
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            regRdData <= 32'h0;
        else if (regRdStrobe)
            case (regAddr)
                CTRL_OFS: regRdData <= {26'h0, ctrlStage_r};
                STAT_OFS: regRdData <= {19'h0, state_r, localOnlyF,
                                        cfgProblem, remoteOverrideIndicator,
                                        manualEff, bypassEff, outputMute,
                                        carrierF, curRate};
                default:  regRdData <= 32'h0;
            endcase
        else
            regRdData <= 32'h0;
    end

    // Assertions
    sequence sApply;
        applyCmd && !recallCmd;
    endsequence
    sequence sLocate;
        locateCmd;
    endsequence

    AST_APPLY_ADOPT: assert property (
        sApply |=> (ctrlAct_r == $past(ctrlStage_r)))
        else $error("apply did not adopt staged selection");
    AST_NO_APPLY_HOLD: assert property (
        !applyCmd && !recallCmd |=> $stable(ctrlAct_r))
        else $error("selection changed without apply");
    AST_RECALL_AUTO: assert property (
        recallCmd |=> !manualEff)
        else $error("recall did not return to auto");
    AST_MUTE_NOSIG: assert property (
        !carrierF |=> outputMute)
        else $error("outputs not muted without input");
    AST_SD_RANGE: assert property (
        sdReclock && (cableF == 10'h15f) |=> outputMute ##0 retimeEnable)
        else $error("reclocked SD over 350m not muted");
    AST_LOCAL_ONLY: assert property (
        localOnlyF [*2] |-> !remoteOverrideIndicator && !manualEff)
        else $error("remote override while local only");
    AST_AUTO_BYPASS: assert property (
        !manualEff && !rateValid |=> retimeRate == RATE_NONE)
        else $error("invalid rate not reported as bypass");
    AST_RECLOCK_LED: assert property (
        bypassEff |=> reclockIndicator && !retimeEnable)
        else $error("bypass not shown or still retiming");
    AST_FAULT_ON: assert property (
        faultF |=> faultIndicator)
        else $error("internal fault not lit");
    AST_LOCATE_FLASH: assert property (
        sLocate ##2 1'b1 |-> busActivityIndicator == $past(flashBus.longFlash))
        else $error("locate did not show long flash");
    AST_INIT_CONFIGURING_INDICATOR: assert property (
        (state_r == ST_INIT) |=> configuringIndicator)
        else $error("configuring LED dark during init");
    AST_RATE_LED: assert property (
        carrierF && !bypassEff && !manualEff && rateValid
        |=> $onehot(rateIndicator))
        else $error("detected rate LED not lit");

endmodule : reclock_da_status_mode_control
